/* File: design/pwrseq_pkg.sv */
// constants and types for the power sequencer and hibernate controller
// What this block does
// R1 - wait 4ms after input supply good
// R2 - charge pump on after 5V good
// R3 - 5V above lockout, 1ms, enable LDOs
// R4 - both LDOs good, 1ms, release reset
// R5 - hibernate turns off regulators and manager
// R6 - wake on timer or button
// R7 - software sets wake config before hibernate
// R8 - wake reruns the whole power-up
// R9 - hibernate keeps only persistent cause bits
// R10 - supply drop records fault, resets core
// R11 - reset held until supplies good, delay
// R12 - unmasked overtemperature fault resets core
// R13 - fault bits survive core reset
// R14 - monitor selector feeds ADC pre-mux
// R15 - temperature warning raises maskable interrupt
// R16 - sleep halts execution only
// R17 - deep sleep also gates chosen peripherals
// R18 - delays counted on always-on clock
// R19 - input supply loss restarts the power-up sequence
`default_nettype none
package pwrseq_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int VM_DLY_MS = 4;
   localparam int VM_DLY_CYC = VM_DLY_MS * CYC_PER_MS;
   localparam int SYS_DLY_MS = 1;
   localparam int SYS_DLY_CYC = SYS_DLY_MS * CYC_PER_MS;
   localparam int RST_DLY_MS = 1;
   localparam int RST_DLY_CYC = RST_DLY_MS * CYC_PER_MS;
   localparam int WAKE_TICK_MS = 25;
   localparam int WAKE_TICK_CYC = WAKE_TICK_MS * CYC_PER_MS;
   localparam int WAKE_MAX_MS = 4000;
   localparam logic [7:0] WAKE_MAX_TICKS = 8'(WAKE_MAX_MS / WAKE_TICK_MS);
   localparam int TMR_W = 20;
   localparam int APB_AW = 8;
   // register byte offsets
   localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] OFS_WAKE = 8'h04;
   localparam logic [APB_AW-1:0] OFS_GATE = 8'h08;
   localparam logic [APB_AW-1:0] OFS_CAUSE = 8'h0C;
   localparam logic [APB_AW-1:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [APB_AW-1:0] OFS_IRQ_CLR = 8'h14;
   localparam logic [APB_AW-1:0] OFS_IRQ_EN = 8'h18;
   localparam logic [APB_AW-1:0] OFS_STATE = 8'h1C;
   // control fields
   localparam int CTRL_HIB = 0;
   localparam int CTRL_SLEEP = 1;
   localparam int CTRL_DEEP = 2;
   localparam int CTRL_TMASK = 3;
   localparam int CTRL_BTN = 4;
   localparam int CTRL_MON_LSB = 8;
   // persistent cause bits
   localparam int CAUSE_N = 7;
   localparam int C_VM = 0;
   localparam int C_SYS = 1;
   localparam int C_AIO = 2;
   localparam int C_CORE = 3;
   localparam int C_TEMP = 4;
   localparam int C_WTMR = 5;
   localparam int C_WBTN = 6;
   // interrupt bits
   localparam int IRQ_N = 2;
   localparam int I_TWARN = 0;
   localparam int I_TFAULT = 1;
   typedef enum logic [2:0] {
      MON_CORE = 3'h0, MON_PUMP = 3'h1, MON_AIO = 3'h2,
      MON_SYS = 3'h3, MON_MOTOR = 3'h4, MON_TEMP = 3'h5
   } mon_sel_t;
   typedef enum logic [7:0] {
      S_OFF = 8'h01, S_VM_WAIT = 8'h02, S_SYS_UP = 8'h04, S_SYS_DLY = 8'h08,
      S_LDO_UP = 8'h10, S_RST_DLY = 8'h20, S_RUN = 8'h40, S_HIB = 8'h80
   } seq_state_t;
endpackage
`default_nettype wire

/* File: design/seq_delay.sv */
// reloadable down counter giving a delay of load cycles
`timescale 1ns/1ps
`default_nettype none
module seq_delay #(
   parameter int W = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic [W-1:0] load,
   // status
   output logic done
);
   logic [W-1:0] cnt_q;
   logic busy_q;
   assign done = busy_q && (cnt_q == '0);
   // loading load-1 makes done appear exactly load cycles after start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
      end else if (start) begin
         cnt_q <= load - 1'b1;
         busy_q <= 1'b1;
      end else if (busy_q && cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule // seq_delay
`default_nettype wire

/* File: design/sticky_flags.sv */
// sticky flag vector, set beats clear, optional wipe
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
   parameter int N = 2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // events and clears
   input wire logic [N-1:0] set,
   input wire logic [N-1:0] clr,
   input wire logic wipe,
   // flags
   output logic [N-1:0] q
);
   logic [N-1:0] q_d;
   // a wipe still keeps events of the same cycle
   assign q_d = wipe ? set : ((q & ~clr) | set);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= q_d;
      end
   end
endmodule // sticky_flags
`default_nettype wire

/* File: design/pwrseq_top.sv */
// power-up sequencer, hibernate and supply monitor with APB registers
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pwrseq_top import pwrseq_pkg::*; #(
   parameter int VM_DLY = VM_DLY_CYC,
   parameter int SYS_DLY = SYS_DLY_CYC,
   parameter int RST_DLY = RST_DLY_CYC,
   parameter int WAKE_TICK = WAKE_TICK_CYC,
   parameter int GATE_N = 8
) (
   // clock and reset, always-on
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // supply comparators
   input wire logic vm_ok,
   input wire logic sys_uvlo_ok,
   input wire logic sys_pgood,
   input wire logic aio_pgood,
   input wire logic core_pgood,
   // temperature comparators and wake pin
   input wire logic temp_warn,
   input wire logic temp_fault,
   input wire logic wake_button_input,
   // regulator enables
   output logic sys_reg_en,
   output logic pump_en,
   output logic aio_reg_en,
   output logic core_reg_en,
   output logic pm_active,
   // core control
   output logic mcu_reset_n,
   output logic cpu_halt,
   output logic [GATE_N-1:0] periph_gate,
   output logic irq,
   // adc pre-mux select
   output mon_sel_t mon_sel
);
   seq_state_t state_q, state_d;
   logic sys_en_q, pump_q, ldo_en_q, rst_n_q, pm_on_q;
   logic sleep_q, deep_q, tmask_q, btn_en_q, hib_btn_q;
   logic tw_prev_q, tf_prev_q, btn_prev_q;
   logic [7:0] wake_q, wake_cnt_q;
   logic [GATE_N-1:0] gate_q, gate_out_q;
   logic [IRQ_N-1:0] irq_en_q, irq_stat;
   logic [CAUSE_N-1:0] cause_q, cause_set, cause_clr;
   logic [IRQ_N-1:0] irq_set, irq_clr;
   logic [31:0] prdata_q, rd_data;
   logic [TMR_W-1:0] tmr_load;
   logic tmr_done, psc_done;

   function automatic logic mapped(input logic [APB_AW-1:0] a);
      mapped = (a == OFS_CTRL) || (a == OFS_WAKE) || (a == OFS_GATE) ||
               (a == OFS_CAUSE) || (a == OFS_IRQ_STAT) || (a == OFS_IRQ_CLR) ||
               (a == OFS_IRQ_EN) || (a == OFS_STATE);
   endfunction

   // apb decode
   wire apb_setup = psel && !penable;
   wire apb_acc = psel && penable;
   wire apb_wr = apb_acc && pwrite;
   wire wr_ctrl = apb_wr && (paddr == OFS_CTRL);
   wire wr_wake = apb_wr && (paddr == OFS_WAKE);
   wire wr_gate = apb_wr && (paddr == OFS_GATE);
   wire wr_cause = apb_wr && (paddr == OFS_CAUSE);
   wire wr_iclr = apb_wr && (paddr == OFS_IRQ_CLR);
   wire wr_ien = apb_wr && (paddr == OFS_IRQ_EN);
   assign pready = 1'b1;
   assign pslverr = apb_acc && !mapped(paddr);
   assign prdata = prdata_q;

   // supply and event decode
   wire in_run = (state_q == S_RUN);
   wire in_hib = (state_q == S_HIB);
   wire all_good = sys_pgood && aio_pgood && core_pgood;
   wire temp_rst = temp_fault && !tmask_q;
   wire hib_go = wr_ctrl && pwdata[CTRL_HIB] && in_run;
   wire hib_entry = !in_hib && (state_d == S_HIB);
   wire wake_tick = in_hib && psc_done;
   wire tmr_wake = wake_tick && (wake_cnt_q == 8'h01);
   wire btn_wake = in_hib && hib_btn_q && wake_button_input && !btn_prev_q;
   wire [2:0] mon_wr = pwdata[CTRL_MON_LSB +: 3];
   wire mon_ok = (mon_wr <= MON_TEMP);
   wire [7:0] wake_wr = (pwdata[7:0] > WAKE_MAX_TICKS) ? WAKE_MAX_TICKS : pwdata[7:0];
   wire sys_on_d = state_d inside {S_SYS_UP, S_SYS_DLY, S_LDO_UP, S_RST_DLY, S_RUN};
   wire ldo_on_d = state_d inside {S_LDO_UP, S_RST_DLY, S_RUN};

   // sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         S_OFF: begin
            if (vm_ok) state_d = S_VM_WAIT;
         end
         S_VM_WAIT: begin
            if (tmr_done) state_d = S_SYS_UP; // R1
         end
         S_SYS_UP: begin
            if (sys_uvlo_ok) state_d = S_SYS_DLY;
         end
         S_SYS_DLY: begin
            if (!sys_uvlo_ok) state_d = S_SYS_UP;
            else if (tmr_done) state_d = S_LDO_UP; // R3
         end
         S_LDO_UP: begin
            if (all_good && !temp_rst) state_d = S_RST_DLY; // R11
         end
         S_RST_DLY: begin
            if (!all_good || temp_rst) state_d = S_LDO_UP; // R11
            else if (tmr_done) state_d = S_RUN; // R4
         end
         S_RUN: begin
            if (!all_good || temp_rst) state_d = S_LDO_UP; // R10 R12
            else if (hib_go) state_d = S_HIB; // R5
         end
         S_HIB: begin
            if (tmr_wake || btn_wake) state_d = S_OFF; // R6 R8
         end
         default: begin
            state_d = S_OFF;
         end
      endcase
      if (!vm_ok) state_d = S_OFF; // R19
   end

   // one timer serves every sequencing delay, restarted on each entry
   wire tmr_start = (state_d != state_q) &&
                    (state_d inside {S_VM_WAIT, S_SYS_DLY, S_RST_DLY});
   assign tmr_load = (state_d == S_VM_WAIT) ? TMR_W'(VM_DLY) :
                     (state_d == S_SYS_DLY) ? TMR_W'(SYS_DLY) : TMR_W'(RST_DLY);

   seq_delay #(.W(TMR_W)) u_seq_tmr ( // R18
      .clk(pclk),
      .rst_n(presetn),
      .start(tmr_start),
      .load(tmr_load),
      .done(tmr_done)
   );

   // wake prescaler is reloaded only at hibernate entry and on each hibernate tick, on the always-on clock
   seq_delay #(.W(TMR_W)) u_wake_psc ( // R18
      .clk(pclk),
      .rst_n(presetn),
      .start(hib_entry || wake_tick),
      .load(TMR_W'(WAKE_TICK)),
      .done(psc_done)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_OFF;
         sys_en_q <= 1'b0;
         pump_q <= 1'b0;
         ldo_en_q <= 1'b0;
         rst_n_q <= 1'b0;
         pm_on_q <= 1'b1;
      end else begin
         state_q <= state_d;
         sys_en_q <= sys_on_d; // R1 R5
         pump_q <= sys_on_d && (pump_q || sys_pgood); // R2
         ldo_en_q <= ldo_on_d; // R3 R5
         rst_n_q <= (state_d == S_RUN); // R4 R10 R11
         pm_on_q <= (state_d != S_HIB); // R5
      end
   end

   // wake setup is copied at entry because the registers are wiped then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt_q <= 8'h00;
         hib_btn_q <= 1'b0;
      end else if (hib_entry) begin
         wake_cnt_q <= wake_q; // R7
         hib_btn_q <= btn_en_q; // R7
      end else if (wake_tick && wake_cnt_q != 8'h00) begin
         wake_cnt_q <= wake_cnt_q - 8'h01; // R6
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tw_prev_q <= 1'b0;
         tf_prev_q <= 1'b0;
         btn_prev_q <= 1'b0;
      end else begin
         tw_prev_q <= temp_warn;
         tf_prev_q <= temp_fault;
         btn_prev_q <= wake_button_input;
      end
   end

   // software registers, lost through hibernate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmask_q <= 1'b0;
         btn_en_q <= 1'b0;
         deep_q <= 1'b0;
         mon_sel <= MON_CORE;
         wake_q <= 8'h00;
         gate_q <= '0;
         irq_en_q <= '0;
      end else if (hib_entry) begin
         tmask_q <= 1'b0; // R9
         btn_en_q <= 1'b0;
         deep_q <= 1'b0;
         mon_sel <= MON_CORE;
         wake_q <= 8'h00;
         gate_q <= '0;
         irq_en_q <= '0;
      end else begin
         if (wr_ctrl) begin
            tmask_q <= pwdata[CTRL_TMASK]; // R12
            btn_en_q <= pwdata[CTRL_BTN];
            deep_q <= pwdata[CTRL_DEEP];
            if (mon_ok) mon_sel <= mon_sel_t'(mon_wr); // R14
         end
         if (wr_wake) wake_q <= wake_wr;
         if (wr_gate) gate_q <= pwdata[GATE_N-1:0];
         if (wr_ien) irq_en_q <= pwdata[IRQ_N-1:0];
      end
   end

   // sleep halts only the core; a pending interrupt wakes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_q <= 1'b0;
         gate_out_q <= '0;
      end else begin
         if (!rst_n_q) sleep_q <= 1'b0;
         else if (wr_ctrl) sleep_q <= pwdata[CTRL_SLEEP]; // R16
         else if (irq) sleep_q <= 1'b0;
         gate_out_q <= (sleep_q && deep_q) ? gate_q : '0; // R17
      end
   end

   // persistent reset cause: survives core reset and hibernate
   always_comb begin
      cause_set = '0;
      cause_set[C_VM] = !in_hib && (state_q != S_OFF) && !vm_ok; // R19
      cause_set[C_SYS] = in_run && !sys_pgood; // R10
      cause_set[C_AIO] = in_run && !aio_pgood; // R10
      cause_set[C_CORE] = in_run && !core_pgood; // R10
      cause_set[C_TEMP] = in_run && temp_rst; // R12
      cause_set[C_WTMR] = tmr_wake;
      cause_set[C_WBTN] = btn_wake;
   end
   assign cause_clr = wr_cause ? pwdata[CAUSE_N-1:0] : '0;

   sticky_flags #(.N(CAUSE_N)) u_cause ( // R13
      .clk(pclk),
      .rst_n(presetn),
      .set(cause_set),
      .clr(cause_clr),
      .wipe(1'b0),
      .q(cause_q)
   );

   assign irq_set[I_TWARN] = temp_warn && !tw_prev_q; // R15
   assign irq_set[I_TFAULT] = temp_fault && !tf_prev_q;
   assign irq_clr = wr_iclr ? pwdata[IRQ_N-1:0] : '0;

   sticky_flags #(.N(IRQ_N)) u_irq (
      .clk(pclk),
      .rst_n(presetn),
      .set(irq_set),
      .clr(irq_clr),
      .wipe(hib_entry),
      .q(irq_stat)
   );

   assign irq = |(irq_stat & irq_en_q); // R15

   // read data is captured in the setup phase, valid in the access phase
   assign rd_data =
      (paddr == OFS_CTRL) ? {21'h0, mon_sel, 3'h0, btn_en_q, tmask_q, deep_q, sleep_q, 1'b0} :
      (paddr == OFS_WAKE) ? {24'h0, wake_q} :
      (paddr == OFS_GATE) ? 32'(gate_q) :
      (paddr == OFS_CAUSE) ? 32'(cause_q) :
      (paddr == OFS_IRQ_STAT) ? 32'(irq_stat) :
      (paddr == OFS_IRQ_EN) ? 32'(irq_en_q) :
      (paddr == OFS_STATE) ? 32'(state_q) : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (apb_setup && !pwrite) begin
         prdata_q <= rd_data;
      end
   end

   assign sys_reg_en = sys_en_q;
   assign pump_en = pump_q;
   assign aio_reg_en = ldo_en_q;
   assign core_reg_en = ldo_en_q;
   assign pm_active = pm_on_q;
   assign mcu_reset_n = rst_n_q;
   assign cpu_halt = sleep_q;
   assign periph_gate = gate_out_q;

   // dwell counter for checking delay lengths
   logic [TMR_W-1:0] dwell_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) dwell_q <= '0;
      else dwell_q <= (state_d != state_q) ? '0 : dwell_q + 1'b1;
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_vm_delay: assert property ( // R1
      in_state_exit(S_VM_WAIT, S_SYS_UP) |-> dwell_q == TMR_W'(VM_DLY - 1))
      else $error("input supply delay wrong");
   a_sys_delay: assert property ( // R3
      (state_q == S_SYS_DLY && state_d == S_LDO_UP) |->
      dwell_q == TMR_W'(SYS_DLY - 1) && sys_uvlo_ok)
      else $error("ldo start delay wrong");
   a_por_delay: assert property ( // R4
      $rose(mcu_reset_n) |-> $past(state_q == S_RST_DLY) &&
      $past(dwell_q) == TMR_W'(RST_DLY - 1))
      else $error("reset release delay wrong");
   a_pump_order: assert property ( // R2
      $rose(pump_en) |-> $past(sys_pgood) && sys_reg_en)
      else $error("pump enabled before 5V good");
   a_hib_off: assert property ( // R5
      in_hib |-> !sys_reg_en && !pump_en && !aio_reg_en && !mcu_reset_n && !pm_active)
      else $error("power left on in hibernate");
   a_btn_wake: assert property ( // R6
      (btn_wake && vm_ok) |=> state_q == S_OFF ##1 state_q == S_VM_WAIT)
      else $error("button wake did not restart");
   a_hib_wipe: assert property ( // R9
      $rose(in_hib) |-> wake_q == 8'h00 && irq_en_q == '0 &&
      cause_q == $past(cause_q))
      else $error("hibernate state not wiped");
   a_fault_rst: assert property ( // R10
      (in_run && vm_ok && !core_pgood) |=> !mcu_reset_n && cause_q[C_CORE])
      else $error("supply fault did not reset");
   a_rst_hold: assert property ( // R11
      (!mcu_reset_n && !all_good) |=> !mcu_reset_n)
      else $error("reset released with bad supply");
   a_temp_mask: assert property ( // R12
      (in_run && temp_fault && tmask_q && all_good && vm_ok && !hib_go) |=> mcu_reset_n)
      else $error("masked temp fault reset core");
   a_warn_irq: assert property ( // R15
      ($rose(temp_warn) && irq_en_q[I_TWARN] && !hib_entry) |=> irq && irq_stat[I_TWARN])
      else $error("temp warning not raised");
   a_lockout: assert property ( // R19
      !vm_ok |=> state_q == S_OFF && !sys_reg_en && !aio_reg_en && !mcu_reset_n)
      else $error("input loss not handled");

   c_reach_run: cover property ($rose(mcu_reset_n));
   c_timer_wake: cover property (tmr_wake ##1 state_q == S_OFF);
   c_btn_wake: cover property (btn_wake);
   c_temp_rst: cover property (in_run && temp_rst ##1 !mcu_reset_n);

   function automatic logic in_state_exit(input seq_state_t a, input seq_state_t b);
      in_state_exit = (state_q == a) && (state_d == b);
   endfunction
endmodule // pwrseq_top
`default_nettype wire

/* File: sim/supply_model.sv */
// comparator model of the supply rails answering the regulator enables
`timescale 1ns/1ps
`default_nettype none
module supply_model (
   // clock
   input wire logic pclk,
   // regulator enables and injected rail drops
   input wire logic sys_en,
   input wire logic ldo_en,
   input wire logic [2:0] drop,
   // comparator outputs: 0 system, 1 analog io, 2 core
   output logic uvlo_ok,
   output logic [2:0] pgood
);
   logic [3:0] s_q = '0;
   logic [3:0] l_q = '0;
   // rails ramp over a few cycles, so good never comes with the enable
   always_ff @(posedge pclk) begin
      s_q <= {s_q[2:0], sys_en};
      l_q <= {l_q[2:0], ldo_en};
   end
   assign uvlo_ok = s_q[1];
   assign pgood[0] = s_q[3] & ~drop[0];
   assign pgood[1] = l_q[3] & ~drop[1];
   assign pgood[2] = l_q[2] & ~drop[2];
endmodule // supply_model
`default_nettype wire

/* File: sim/test_power_sequence_hibernate_ctrl.sv */
// self-checking bench for the power sequencer and hibernate controller
`timescale 1ns/1ps
`default_nettype none
module test_power_sequence_hibernate_ctrl import pwrseq_pkg::*; ();
   localparam int VM_D = 20;
   localparam int SYS_D = 10;
   localparam int RST_D = 10;
   localparam int TICK = 8;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rv, v;
   logic pready, pslverr, last_err, sys_uvlo_ok;
   logic vm_ok = 0;
   logic temp_warn = 0;
   logic temp_fault = 0;
   logic wake_button_input = 0;
   logic [2:0] pgood;
   logic [2:0] drop = '0;
   logic sys_reg_en, pump_en, aio_reg_en, core_reg_en, pm_active;
   logic mcu_reset_n, cpu_halt, irq;
   logic [7:0] periph_gate;
   mon_sel_t mon_sel;
   int err_count = 0;
   int checks_done = 0;
   int cause_m = 0;
   int n;
   always #20 pclk = ~pclk;
   pwrseq_top #(.VM_DLY(VM_D), .SYS_DLY(SYS_D), .RST_DLY(RST_D), .WAKE_TICK(TICK),
      .GATE_N(8)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .vm_ok(vm_ok), .sys_uvlo_ok(sys_uvlo_ok), .sys_pgood(pgood[0]), .aio_pgood(pgood[1]),
      .core_pgood(pgood[2]), .temp_warn(temp_warn), .temp_fault(temp_fault),
      .wake_button_input(wake_button_input), .sys_reg_en(sys_reg_en), .pump_en(pump_en),
      .aio_reg_en(aio_reg_en), .core_reg_en(core_reg_en), .pm_active(pm_active),
      .mcu_reset_n(mcu_reset_n), .cpu_halt(cpu_halt), .periph_gate(periph_gate),
      .irq(irq), .mon_sel(mon_sel));
   supply_model sup (.pclk(pclk), .sys_en(sys_reg_en), .ldo_en(aio_reg_en & core_reg_en),
      .drop(drop), .uvlo_ok(sys_uvlo_ok), .pgood(pgood));
   task automatic give_verdict;
      if (err_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         err_count++;
         give_verdict;
      end
      rv = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return sys_reg_en;
         1: return aio_reg_en;
         default: return mcu_reset_n;
      endcase
   endfunction
   // counts falling edges so registered outputs have settled
   task automatic wait_for(input int s, input logic lvl);
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (pick(s) !== lvl && n < 2000);
      if (n >= 2000) begin
         err_count++;
         give_verdict;
      end
   endtask
   task automatic power_up(input int lo);
      wait_for(0, 1);
      check("sys en", n >= lo && n <= lo + 4, 1);
      check("pump early", pump_en, 0);
      wait_for(1, 1);
      check("ldo en", n >= SYS_D + 2 && n <= SYS_D + 5, 1);
      check("pump core", {pump_en, core_reg_en}, 2'b11);
      wait_for(2, 1);
      check("rst rel", n >= RST_D + 4 && n <= RST_D + 7, 1);
   endtask
   task automatic cause_chk;
      apb(0, OFS_CAUSE, 0);
      check("cause", rv, cause_m);
      apb(1, OFS_CAUSE, 32'h7F);
      cause_m = 0;
   endtask
   initial begin
      repeat (100000) @(posedge pclk);
      err_count++;
      give_verdict;
   end
   initial begin
      void'($urandom(32'h2F1A));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      vm_ok <= 1'b1;
      power_up(VM_D + 1);
      apb(0, OFS_STATE, 0);
      check("state", rv, S_RUN);
      apb(0, 8'h40, 0);
      check("unmapped err", last_err, 1);
      check("unmapped data", rv, 0);
      for (int i = 0; i < 4; i++) begin
         v = (i < 2) ? 160 + i : $urandom % 256;
         apb(1, OFS_WAKE, v);
         apb(0, OFS_WAKE, 0);
         check("wake", rv, (v > 160) ? 160 : v);
      end
      for (int i = 0; i < 7; i++) begin
         apb(1, OFS_CTRL, i << 8);
         @(negedge pclk);
         check("mon", mon_sel, (i < 6) ? i : 5);
      end
      apb(1, OFS_CTRL, 32'h2);
      @(negedge pclk);
      check("sleep", {cpu_halt, sys_reg_en, aio_reg_en, mcu_reset_n}, 4'hF);
      v = $urandom;
      apb(1, OFS_GATE, v & 32'hFF);
      // deep sleep needs the sleep bit too; the gate output lags one edge
      apb(1, OFS_CTRL, 32'h6);
      repeat (2) @(negedge pclk);
      check("deep", {cpu_halt, periph_gate}, {1'b1, v[7:0]});
      apb(1, OFS_CTRL, 0);
      repeat (2) @(negedge pclk);
      check("awake", {cpu_halt, periph_gate}, 0);
      apb(1, OFS_IRQ_EN, 32'h1);
      @(posedge pclk);
      temp_warn <= 1'b1;
      @(posedge pclk);
      temp_warn <= 1'b0;
      repeat (2) @(negedge pclk);
      check("warn irq", {irq, mcu_reset_n}, 2'b11);
      apb(0, OFS_IRQ_STAT, 0);
      check("irq stat", rv, 32'h1);
      apb(1, OFS_IRQ_EN, 0);
      @(negedge pclk);
      check("irq mask", irq, 0);
      apb(1, OFS_IRQ_EN, 32'h1);
      apb(1, OFS_IRQ_CLR, 32'h1);
      @(negedge pclk);
      check("irq clr", irq, 0);
      apb(0, OFS_IRQ_CLR, 0);
      check("clr reads", rv, 0);
      for (int i = 0; i < 3; i++) begin
         @(posedge pclk);
         drop[i] <= 1'b1;
         wait_for(2, 0);
         check("drop rst", n <= 2, 1);
         cause_m |= 1 << (i + 1);
         repeat (3) @(posedge pclk);
         drop[i] <= 1'b0;
         wait_for(2, 1);
         check("drop hold", n >= RST_D && n <= RST_D + 4, 1);
      end
      apb(1, OFS_CTRL, 32'h8);
      @(posedge pclk);
      temp_fault <= 1'b1;
      repeat (4) @(negedge pclk);
      check("masked temp", mcu_reset_n, 1);
      apb(1, OFS_CTRL, 0);
      wait_for(2, 0);
      check("temp rst", n <= 2, 1);
      cause_m |= 1 << C_TEMP;
      @(posedge pclk);
      temp_fault <= 1'b0;
      wait_for(2, 1);
      check("temp rel", n >= RST_D && n <= RST_D + 4, 1);
      // timer is set before the request, as software must
      apb(1, OFS_WAKE, 32'h2);
      apb(1, OFS_CTRL, 32'h1);
      @(negedge pclk);
      check("hib off", {sys_reg_en, pump_en, aio_reg_en, core_reg_en, pm_active,
         mcu_reset_n}, 0);
      power_up(2 * TICK + VM_D);
      cause_m |= 1 << C_WTMR;
      cause_chk;
      apb(0, OFS_WAKE, 0);
      check("wake wiped", rv, 0);
      // button enable must stand before the hibernate request
      apb(1, OFS_CTRL, 32'h10);
      apb(1, OFS_CTRL, 32'h11);
      repeat (30) @(negedge pclk);
      check("no timer", sys_reg_en, 0);
      @(posedge pclk);
      wake_button_input <= 1'b1;
      @(posedge pclk);
      wake_button_input <= 1'b0;
      power_up(VM_D);
      cause_m |= 1 << C_WBTN;
      cause_chk;
      @(posedge pclk);
      vm_ok <= 1'b0;
      repeat (2) @(negedge pclk);
      check("vm loss", {sys_reg_en, pump_en, aio_reg_en, core_reg_en, mcu_reset_n}, 0);
      cause_m |= 1 << C_VM;
      @(posedge pclk);
      vm_ok <= 1'b1;
      power_up(VM_D + 1);
      cause_chk;
      give_verdict;
   end
endmodule // test_power_sequence_hibernate_ctrl
`default_nettype wire
